//--- acs_pkg.sv
package acs_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // Frame layout on the serial link.
    localparam int FRAME_BITS = 16;
    localparam int CFG_FLAG_BIT = 15;
    localparam int SEL_HI = 15;
    localparam int SEL_LO = 11;
    localparam int FIELD_HI = 10;
    localparam int FIELD_LO = 3;
    localparam int COMMON_REF_BIT = 2;
    localparam int NIBBLE_BITS = 4;

    // Register select codes in the top five bits of a configuration frame.
    localparam logic [4:0] SEL_PSEUDO_DIFF = 5'h11;
    localparam logic [4:0] SEL_BIPOLAR = 5'h12;
    localparam logic [4:0] SEL_SEQUENCE_LENGTH_FIELD = 5'h16;

    // Reset values of the configuration registers.
    localparam logic [15:0] CFG_RESET = 16'h0000;
    localparam logic [7:0] SEQUENCE_LENGTH_FIELD_RESET = 8'h00;

    // Deepest channel sequence.
    localparam int SEQ_MAX = 256;

    ////////////////////////////////////////////////////////////////////////////////
    // Timing: the host divides pclk down to the link clock.
    localparam int PCLK_PERIOD_PS = 8000;
    localparam int LINK_PERIOD_PS = 64000;
    localparam int LINK_HALF_CYC = LINK_PERIOD_PS / (2 * PCLK_PERIOD_PS);

    ////////////////////////////////////////////////////////////////////////////////
    // Host register map on APB.
    localparam logic [11:0] ADDR_TX_DATA = 12'h000;
    localparam logic [11:0] ADDR_CTRL = 12'h004;
    localparam logic [11:0] ADDR_STATUS = 12'h008;
    localparam int CTRL_KEEP_OPEN_BIT = 0;
    localparam int STAT_BUSY_BIT = 0;
    localparam int STAT_OPEN_BIT = 1;
    localparam int STAT_PATTERN_DUE_BIT = 2;

    // Coding chosen for one selected channel.
    typedef struct packed {
        logic pair;
        logic common_ref;
        logic twos_comp;
    } acs_coding_t;

endpackage : acs_pkg

//--- acs_link_if.sv
`timescale 1ns/1ps
interface acs_link_if;
    logic sclk;
    logic cs_n;
    logic mosi;

    // The converter end listens, the host end drives.
    modport dev (input sclk, input cs_n, input mosi);
    modport host (output sclk, output cs_n, output mosi);
endinterface : acs_link_if

//--- acs_dev.sv
`timescale 1ns/1ps
// Notes on behaviour
// - Code 10001 selects the pseudo-differential register.
// - Code 10010 selects the bipolar register.
// - Bits 10..3 mark pairs pseudo-differential.
// - Bit 2 refers inputs to shared negative.
// - Bits 10..3 mark pairs bipolar differential.
// - Bipolar-only pair reports two's complement.
// - Pseudo-differential beats bipolar, straight binary.
// - Pseudo-differential-only pair converts as pair.
// - Common reference overrides pair bits.
// - Same decision for every even/odd pair.
// - Select field or bitmap chooses channels.
// - Sequence holds up to 256 entries.
// - Pattern arrives as 4-bit channel nibbles.
// - Length frame first, then pattern frame.
// - Pattern activates at next chip-select fall.
// - Missing entries read as channel 0.
// - Excess nibbles ignored until chip-select rises.
// - Broken nibble is not stored; it reads as channel 0.
// - Mode write restarts at first entry.
// - Shutdown accepted during last result.
// - Host reloads pattern after length change.
// - Length code 10110, field is length-1.
// - Top bit one configures, zero commands.
module acs_dev (
    // Clock and reset.
    input wire logic pclk,
    input wire logic presetn,
    // Serial link from the host.
    acs_link_if.dev link,
    // Scan control from the conversion engine.
    input wire logic seq_mode,
    input wire logic scan_custom,
    input wire logic [3:0] channel_select_field,
    input wire logic [15:0] scan_bitmap,
    input wire logic seq_advance,
    // Configuration seen by the analog front end.
    output logic [15:0] pseudo_diff_pair_config,
    output logic [15:0] bipolar_pair_config,
    output logic [7:0] sequence_length_field,
    // Channel choice and coding of the next conversion.
    output logic [3:0] conv_channel,
    output logic [15:0] conv_mask,
    output logic conv_pair,
    output logic conv_common_ref,
    output logic conv_twos_comp,
    output logic [7:0] seq_index,
    output logic seq_last,
    // Mode-control instructions.
    output logic mode_valid,
    output logic [15:0] mode_word,
    output logic shutdown_ack
);

    ////////////////////////////////////////////////////////////////////////////////
    // Coding of one channel from the two pair registers.
    function automatic acs_pkg::acs_coding_t coding(input logic [3:0] ch, input logic [15:0] uni,
                                                    input logic [15:0] bip);
        acs_pkg::acs_coding_t c;
        logic u;
        logic b;
        u = uni[acs_pkg::FIELD_HI - int'(ch[3:1])];
        b = bip[acs_pkg::FIELD_HI - int'(ch[3:1])];
        c.common_ref = uni[acs_pkg::COMMON_REF_BIT];
        c.pair = !c.common_ref && (u || b);
        c.twos_comp = !c.common_ref && !u && b;
        return c;
    endfunction : coding

    ////////////////////////////////////////////////////////////////////////////////
    // Two-flop synchronisers; the extra stage on clock and select finds edges.
    logic [2:0] sclk_s_q;
    logic [2:0] cs_s_q;
    logic [1:0] mosi_s_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sclk_s_q <= 3'h0;
            cs_s_q <= 3'h7;
            mosi_s_q <= 2'h0;
        end else begin
            sclk_s_q <= {sclk_s_q[1:0], link.sclk};
            cs_s_q <= {cs_s_q[1:0], link.cs_n};
            mosi_s_q <= {mosi_s_q[0], link.mosi};
        end
    end

    logic sclk_rise;
    logic cs_fall;
    logic cs_rise;
    logic bit_in;

    // Edge events on the link, all in the pclk domain.
    assign sclk_rise = sclk_s_q[1] && !sclk_s_q[2] && !cs_s_q[1];
    assign cs_fall = !cs_s_q[1] && cs_s_q[2];
    assign cs_rise = cs_s_q[1] && !cs_s_q[2];
    assign bit_in = mosi_s_q[1];

    ////////////////////////////////////////////////////////////////////////////////
    // Frame receiver state.
    logic [10:0] bit_cnt_q;
    logic [15:0] shift_q;
    logic [15:0] word;
    logic word_done;
    logic pat_frame_q;
    logic expect_pat_q;
    logic pend_ready_q;
    logic act_bank_q;
    logic [7:0] pend_len_q;
    logic [8:0] pend_cnt_q;
    logic [7:0] act_len_q;
    logic [8:0] act_cnt_q;
    logic nib_store;
    logic [3:0] seq_mem [2][acs_pkg::SEQ_MAX];

    // A whole 16-bit word has arrived on a non-pattern frame.
    assign word = {shift_q[14:0], bit_in};
    assign word_done = sclk_rise && !pat_frame_q && (bit_cnt_q == 11'(acs_pkg::FRAME_BITS - 1));
    // A nibble completes and still fits the programmed length.
    assign nib_store = sclk_rise && pat_frame_q && (bit_cnt_q[1:0] == 2'h3)
                       && (pend_cnt_q <= {1'b0, pend_len_q});

    // Bit counter and shifter; the counter holds at its end while extra bits keep shifting in.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bit_cnt_q <= 11'h000;
            shift_q <= 16'h0000;
        end else if (cs_fall) begin
            bit_cnt_q <= 11'h000;
        end else if (sclk_rise) begin
            shift_q <= word;
            if (bit_cnt_q != 11'h7FF) begin
                bit_cnt_q <= bit_cnt_q + 11'h001;
            end
        end
    end

    // Configuration registers; low unused bits are kept but not acted on.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pseudo_diff_pair_config <= acs_pkg::CFG_RESET;
            bipolar_pair_config <= acs_pkg::CFG_RESET;
            pend_len_q <= acs_pkg::SEQUENCE_LENGTH_FIELD_RESET;
        end else if (word_done && word[acs_pkg::CFG_FLAG_BIT]) begin
            case (word[acs_pkg::SEL_HI:acs_pkg::SEL_LO])
                acs_pkg::SEL_PSEUDO_DIFF: pseudo_diff_pair_config <= word;
                acs_pkg::SEL_BIPOLAR: bipolar_pair_config <= word;
                acs_pkg::SEL_SEQUENCE_LENGTH_FIELD: pend_len_q <= word[acs_pkg::FIELD_HI:acs_pkg::FIELD_LO];
                default: ;
            endcase
        end
    end

    // Frame sequencing: a length frame arms the next frame as the pattern frame.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            expect_pat_q <= 1'b0;
            pat_frame_q <= 1'b0;
            pend_ready_q <= 1'b0;
            pend_cnt_q <= 9'h000;
            act_bank_q <= 1'b0;
            act_len_q <= acs_pkg::SEQUENCE_LENGTH_FIELD_RESET;
            act_cnt_q <= 9'h000;
        end else begin
            if (cs_fall) begin
                pat_frame_q <= expect_pat_q;
                expect_pat_q <= 1'b0;
                if (expect_pat_q) begin
                    pend_cnt_q <= 9'h000;
                end
                if (pend_ready_q) begin
                    act_bank_q <= !act_bank_q;
                    act_len_q <= pend_len_q;
                    act_cnt_q <= pend_cnt_q;
                    pend_ready_q <= 1'b0;
                end
            end else if (cs_rise && pat_frame_q) begin
                pat_frame_q <= 1'b0;
                pend_ready_q <= 1'b1;
            end else if (nib_store) begin
                pend_cnt_q <= pend_cnt_q + 9'h001;
            end
            if (word_done && word[acs_pkg::CFG_FLAG_BIT]
                && word[acs_pkg::SEL_HI:acs_pkg::SEL_LO] == acs_pkg::SEL_SEQUENCE_LENGTH_FIELD) begin
                expect_pat_q <= 1'b1;
                pend_ready_q <= 1'b0;
            end
        end
    end

    // Pattern store: nibbles fill the idle bank, MSB first.
    always_ff @(posedge pclk) begin
        if (nib_store) begin
            seq_mem[!act_bank_q][pend_cnt_q[7:0]] <= {shift_q[2:0], bit_in};
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Sequence walker and mode-control instructions.
    logic [7:0] idx_q;
    logic [3:0] entry;
    logic [3:0] chan_d;
    logic last_d;
    logic mode_hit;

    assign mode_hit = word_done && !word[acs_pkg::CFG_FLAG_BIT];
    // Entries beyond those delivered, or cut short, read as channel 0.
    assign entry = ({1'b0, idx_q} < act_cnt_q) ? seq_mem[act_bank_q][idx_q] : 4'h0;
    assign last_d = (idx_q == act_len_q);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            idx_q <= 8'h00;
        end else if (mode_hit || (cs_fall && pend_ready_q)) begin
            idx_q <= 8'h00;
        end else if (seq_advance) begin
            idx_q <= last_d ? 8'h00 : idx_q + 8'h01;
        end
    end

    // Mode word out, with shutdown taken while the last result is read.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_valid <= 1'b0;
            mode_word <= 16'h0000;
            shutdown_ack <= 1'b0;
        end else begin
            mode_valid <= mode_hit;
            shutdown_ack <= mode_hit && seq_mode && last_d;
            if (mode_hit) begin
                mode_word <= word;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Channel choice and coding for the conversion engine.
    assign chan_d = seq_mode ? entry : channel_select_field;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            conv_channel <= 4'h0;
            conv_mask <= 16'h0000;
            conv_pair <= 1'b0;
            conv_common_ref <= 1'b0;
            conv_twos_comp <= 1'b0;
            seq_index <= 8'h00;
            seq_last <= 1'b0;
            sequence_length_field <= acs_pkg::SEQUENCE_LENGTH_FIELD_RESET;
        end else begin
            conv_channel <= chan_d;
            conv_mask <= scan_custom ? scan_bitmap : (16'h0001 << chan_d);
            {conv_pair, conv_common_ref, conv_twos_comp} <=
                coding(chan_d, pseudo_diff_pair_config, bipolar_pair_config);
            seq_index <= idx_q;
            seq_last <= last_d;
            sequence_length_field <= act_len_q;
        end
    end

endmodule : acs_dev

//--- acs_host.sv
`timescale 1ns/1ps
module acs_host (
    // Clock and reset.
    input wire logic pclk,
    input wire logic presetn,
    // APB slave.
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Serial link to the converter.
    acs_link_if.host link
);

    typedef enum logic [2:0] {ST_IDLE, ST_LO, ST_HI, ST_END, ST_GAP} acs_host_st_t;

    acs_host_st_t st_q;
    logic [15:0] sh_q;
    logic [4:0] bits_q;
    logic [7:0] div_q;
    logic keep_open_q;
    logic due_q;
    logic cs_n_q;
    logic sclk_q;
    logic mosi_q;
    logic half;
    logic busy;
    logic wr_acc;
    logic rd_setup;
    logic map_ok;
    logic tx_wr;

    ////////////////////////////////////////////////////////////////////////////////
    // Bus decode: no wait states, errors on unmapped or busy data writes.
    assign busy = (st_q != ST_IDLE);
    assign map_ok = (paddr == acs_pkg::ADDR_TX_DATA) || (paddr == acs_pkg::ADDR_CTRL)
                    || (paddr == acs_pkg::ADDR_STATUS);
    assign wr_acc = psel && penable && pwrite;
    assign rd_setup = psel && !penable && !pwrite;
    assign tx_wr = wr_acc && (paddr == acs_pkg::ADDR_TX_DATA) && !busy;
    assign pready = 1'b1;
    assign pslverr = psel && penable && (!map_ok
                     || (pwrite && paddr == acs_pkg::ADDR_TX_DATA && busy));
    assign half = (div_q == 8'(acs_pkg::LINK_HALF_CYC - 1));
    assign link.cs_n = cs_n_q;
    assign link.sclk = sclk_q;
    assign link.mosi = mosi_q;

    // Read data is captured in the setup cycle so it stands in the access phase.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (rd_setup) begin
            prdata <= 32'h0000_0000;
            if (paddr == acs_pkg::ADDR_CTRL) begin
                prdata[acs_pkg::CTRL_KEEP_OPEN_BIT] <= keep_open_q;
            end else if (paddr == acs_pkg::ADDR_STATUS) begin
                prdata[acs_pkg::STAT_BUSY_BIT] <= busy;
                prdata[acs_pkg::STAT_OPEN_BIT] <= !cs_n_q;
                prdata[acs_pkg::STAT_PATTERN_DUE_BIT] <= due_q;
            end
        end
    end

    // Control register.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            keep_open_q <= 1'b0;
        end else if (wr_acc && paddr == acs_pkg::ADDR_CTRL) begin
            keep_open_q <= pwdata[acs_pkg::CTRL_KEEP_OPEN_BIT];
        end
    end

    // Pattern-due flag: a length frame leaves the next frame owed as the pattern.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            due_q <= 1'b0;
        end else if (tx_wr && cs_n_q) begin
            due_q <= pwdata[acs_pkg::CFG_FLAG_BIT]
                     && pwdata[acs_pkg::SEL_HI:acs_pkg::SEL_LO] == acs_pkg::SEL_SEQUENCE_LENGTH_FIELD;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Link shifter: data changes on the falling clock, the converter samples rising.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q <= ST_IDLE;
            sh_q <= 16'h0000;
            bits_q <= 5'h00;
            div_q <= 8'h00;
            cs_n_q <= 1'b1;
            sclk_q <= 1'b0;
            mosi_q <= 1'b0;
        end else begin
            div_q <= (busy && !half) ? div_q + 8'h01 : 8'h00;
            case (st_q)
                ST_IDLE: begin
                    if (tx_wr) begin
                        sh_q <= pwdata[15:0];
                        mosi_q <= pwdata[acs_pkg::CFG_FLAG_BIT];
                        bits_q <= 5'(acs_pkg::FRAME_BITS);
                        cs_n_q <= 1'b0;
                        st_q <= ST_LO;
                    end else if (wr_acc && paddr == acs_pkg::ADDR_CTRL && !cs_n_q
                                 && !pwdata[acs_pkg::CTRL_KEEP_OPEN_BIT]) begin
                        cs_n_q <= 1'b1;
                        st_q <= ST_GAP;
                    end
                end
                ST_LO: begin
                    if (half) begin
                        sclk_q <= 1'b1;
                        st_q <= ST_HI;
                    end
                end
                ST_HI: begin
                    if (half) begin
                        sclk_q <= 1'b0;
                        bits_q <= bits_q - 5'h01;
                        sh_q <= {sh_q[14:0], 1'b0};
                        mosi_q <= sh_q[14];
                        st_q <= (bits_q == 5'h01) ? ST_END : ST_LO;
                    end
                end
                ST_END: begin
                    if (half) begin
                        cs_n_q <= !keep_open_q; // Select stays low only when asked to.
                        st_q <= keep_open_q ? ST_IDLE : ST_GAP;
                    end
                end
                ST_GAP: begin
                    if (half) begin
                        st_q <= ST_IDLE;
                    end
                end
                default: st_q <= ST_IDLE;
            endcase
        end
    end

endmodule : acs_host

//--- acs_link_sva.sv
`timescale 1ns/1ps
module acs_link_sva (
    // Clock and reset.
    input wire logic pclk,
    input wire logic presetn,
    // Link wires.
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic mosi
);
    logic [9:0] bits_q;
    logic sclk_q;

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    ////////////////////////////////////////////////////////////////////////////////
    // Counts the link clock rises inside one chip-select frame.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bits_q <= 10'h000;
            sclk_q <= 1'b0;
        end else begin
            sclk_q <= sclk;
            if (cs_n) begin
                bits_q <= 10'h000;
            end else if (sclk && !sclk_q) begin
                bits_q <= bits_q + 10'h001;
            end
        end
    end

    chk_sclk_idle_low: assert property (cs_n |-> !sclk)
        else $error("Link clock high outside a frame.");
    chk_sclk_high_time: assert property ($rose(sclk) |-> sclk [*4] ##1 !sclk)
        else $error("Link clock high phase is not four cycles.");
    chk_sclk_low_time: assert property ($fell(sclk) |-> !sclk [*4])
        else $error("Link clock low phase is too short.");
    chk_mosi_hold: assert property ($changed(mosi) |-> !sclk)
        else $error("Data changed while the link clock was high.");
    chk_cs_gap: assert property ($rose(cs_n) |-> cs_n [*4])
        else $error("Gap between frames is too short.");
    chk_cs_lead: assert property ($fell(cs_n) |-> !sclk [*3])
        else $error("Link clock rose too soon after frame start.");
    chk_first_bit: assert property ($fell(cs_n) |-> ##[1:16] $rose(sclk))
        else $error("No data bit followed the frame start.");
    chk_frame_whole: assert property ($rose(cs_n) |-> bits_q[3:0] == 4'h0)
        else $error("Frame did not carry whole sixteen-bit words.");

    // Main traffic shapes.
    cov_word_frame: cover property ($rose(cs_n) && bits_q == 10'h010);
    cov_long_frame: cover property ($rose(cs_n) && bits_q > 10'h010);
    cov_config_bit: cover property ($fell(cs_n) && mosi);
endmodule : acs_link_sva

//--- adc_input_config_sequencer_tb.sv
`timescale 1ns/1ps
module adc_input_config_sequencer_tb;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, r;
    logic seq_mode, scan_custom, seq_advance, e;
    logic [3:0] csf;
    logic [15:0] bitmap, pd_cfg, bp_cfg, mask, mword;
    logic [7:0] slen, sidx;
    logic [3:0] chan;
    logic c_pair, c_com, c_twos, s_last, mvalid, sd_ack, mv_seen, sd_seen;
    logic [15:0] u, b;
    int fails = 0;
    int n_checks = 0;

    acs_link_if link ();
    acs_host i_acs_host (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .link(link));
    acs_dev i_acs_dev (.pclk(pclk), .presetn(presetn), .link(link), .seq_mode(seq_mode),
        .scan_custom(scan_custom), .channel_select_field(csf), .scan_bitmap(bitmap),
        .seq_advance(seq_advance), .pseudo_diff_pair_config(pd_cfg),
        .bipolar_pair_config(bp_cfg), .sequence_length_field(slen), .conv_channel(chan),
        .conv_mask(mask), .conv_pair(c_pair), .conv_common_ref(c_com),
        .conv_twos_comp(c_twos), .seq_index(sidx), .seq_last(s_last), .mode_valid(mvalid),
        .mode_word(mword), .shutdown_ack(sd_ack));
    acs_link_sva i_acs_link_sva (.pclk(pclk), .presetn(presetn), .sclk(link.sclk),
        .cs_n(link.cs_n), .mosi(link.mosi));

    ////////////////////////////////////////////////////////////////////////////////
    // Clock, and sticky flags for the one-cycle device pulses.
    always #4 pclk = ~pclk;
    always @(posedge pclk) begin
        if (mvalid === 1'b1) mv_seen <= 1'b1;
        if (sd_ack === 1'b1) sd_seen <= 1'b1;
    end

    task automatic complete_run();
        $display("Checks %0d, mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : complete_run

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            fails++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check

    // One APB transfer; entered and left just after a rising edge.
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb

    // Sends one word once the host is free, then waits for the link to fall quiet.
    task automatic send(input logic [15:0] w);
        do apb(1'b0, acs_pkg::ADDR_STATUS, 32'h0); while (r[acs_pkg::STAT_BUSY_BIT] !== 1'b0);
        apb(1'b1, acs_pkg::ADDR_TX_DATA, {16'h0000, w});
        do apb(1'b0, acs_pkg::ADDR_STATUS, 32'h0); while (r[1:0] !== 2'b00 && r[0] !== 1'b0);
        repeat (8) @(posedge pclk);
    endtask : send

    function automatic logic [2:0] exp_code(logic [15:0] pu, logic [15:0] pb, logic [3:0] ch);
        logic c, uu, bb;
        c = pu[acs_pkg::COMMON_REF_BIT];
        uu = pu[10 - ch[3:1]];
        bb = pb[10 - ch[3:1]];
        return {!c & (uu | bb), c, !c & !uu & bb};
    endfunction : exp_code

    // Loads a length and a pattern of up to four words, then starts with a mode frame.
    task automatic run_seq(input int n, input int nw, input logic [63:0] pat);
        logic [3:0] ent;
        send({acs_pkg::SEL_SEQUENCE_LENGTH_FIELD, 8'(n - 1), 3'h0});
        apb(1'b0, acs_pkg::ADDR_STATUS, 32'h0);
        check(32'(r[acs_pkg::STAT_PATTERN_DUE_BIT]), 32'h1);
        apb(1'b1, acs_pkg::ADDR_CTRL, 32'h1);
        for (int i = 0; i < nw; i++) begin
            send(pat[63 - 16 * i -: 16]);
            check(32'(r[acs_pkg::STAT_OPEN_BIT]), 32'h1);
        end
        apb(1'b1, acs_pkg::ADDR_CTRL, 32'h0);
        mv_seen <= 1'b0;
        sd_seen <= 1'b0;
        send(16'h0ABC);
        check(32'({mv_seen, sd_seen, mword}), 32'h2_0ABC);
        check(32'(slen), 32'(n - 1));
        for (int i = 0; i < n; i++) begin
            ent = (i < 4 * nw) ? pat[63 - 4 * i -: 4] : 4'h0;
            check(32'({chan, s_last, sidx}), 32'({ent, i == n - 1, 8'(i)}));
            if (i < n - 1) begin
                seq_advance <= 1'b1;
                @(posedge pclk);
                seq_advance <= 1'b0;
                repeat (3) @(posedge pclk);
            end
        end
        sd_seen <= 1'b0;
        send(16'h0ABC);
        check(32'(sd_seen), 32'h1);
        check(32'(chan), 32'(pat[63:60]));
    endtask : run_seq

    ////////////////////////////////////////////////////////////////////////////////
    // Main sequence.
    initial begin
        {psel, penable, pwrite, paddr, pwdata} <= '0;
        {seq_mode, scan_custom, seq_advance, csf, bitmap, mv_seen, sd_seen} <= '0;
        void'($urandom(49885));
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        check({pd_cfg, bp_cfg}, {acs_pkg::CFG_RESET, acs_pkg::CFG_RESET});
        check(32'(slen), 32'(acs_pkg::SEQUENCE_LENGTH_FIELD_RESET));
        apb(1'b0, 12'h00C, 32'h0);
        check(32'(e), 32'h1);
        $display("Test reset and map done");
        for (int k = 0; k < 4; k++) begin
            u = {5'h00, 11'($urandom)};
            b = {5'h00, 11'($urandom)};
            u[2] = (k == 3);
            if (k == 2) {u[10:3], b[10:3]} = 16'hFFFF;
            send({acs_pkg::SEL_PSEUDO_DIFF, u[10:0]});
            send({acs_pkg::SEL_BIPOLAR, b[10:0]});
            check({pd_cfg, bp_cfg}, {5'h11, u[10:0], 5'h12, b[10:0]});
            for (int ch = 0; ch < 16; ch++) begin
                csf <= 4'(ch);
                scan_custom <= ch[0];
                bitmap <= 16'($urandom);
                repeat (3) @(posedge pclk);
                check(32'({c_pair, c_com, c_twos}), 32'(exp_code(u, b, 4'(ch))));
                check(32'(mask), 32'(ch[0] ? bitmap : 16'h0001 << ch));
            end
        end
        $display("Test pair coding done");
        seq_mode <= 1'b1;
        run_seq(2, 1, 64'h53A7_0000_0000_0000);
        run_seq(6, 1, {16'($urandom), 48'h0});
        run_seq(256, 4, {32'($urandom), 32'($urandom)});
        $display("Test sequencer done");
        complete_run();
    end

    // Cuts a hang short.
    initial begin
        repeat (90000) @(posedge pclk);
        fails++;
        complete_run();
    end
endmodule : adc_input_config_sequencer_tb
